// ==== bench/rx_front_model.sv ====
// analog front end stand-in: oscillator, pll, error meter, converter
// assumes block enables from the sequencer; drives on the falling edge
module rx_front_model
	import rx_seq_pkg::*;
#(
	parameter int OSC_DLY = 20,
	parameter int PLL_DLY = 30,
	parameter logic [15:0] FERR = 16'hFFF0,
	parameter logic [7:0] ADC_VAL = 8'h5A
) (
	input wire logic i_clock,
	input wire block_en_t i_block_en,
	input wire logic i_temp_running_flag,
	output logic o_osc_ready = 1'b0,
	output logic o_pll_locked = 1'b0,
	output logic [15:0] o_freq_error_value = 16'h0000,
	output logic o_freq_error_valid = 1'b0,
	output logic [7:0] o_adc_sample = 8'h00,
	output logic o_adc_valid = 1'b0
);
	timeunit 1ns;
	timeprecision 100ps;
	int osc_n = 0, pll_n = 0, fe_n = 0, tp_n = 0;
	always @(negedge i_clock) begin
		osc_n = i_block_en.osc_on ? osc_n + 1 : 0;
		pll_n = i_block_en.synth_on ? pll_n + 1 : 0;
		fe_n = i_block_en.wide_bw ? fe_n + 1 : 0;
		tp_n = i_temp_running_flag ? tp_n + 1 : 0;
		o_osc_ready <= osc_n > OSC_DLY;
		o_pll_locked <= pll_n > PLL_DLY;
		// error only in wide bandwidth; stale value inverted
		o_freq_error_valid <= fe_n > 8;
		o_freq_error_value <= (fe_n > 8) ? FERR : ~FERR;
		o_adc_valid <= tp_n == 10;
		o_adc_sample <= (tp_n == 10) ? ADC_VAL : ~ADC_VAL;
	end
endmodule : rx_front_model

// ==== bench/rx_mode_sequencer_properties.sv ====
// port checker for the receive mode sequencer
// assumes one clock domain and a synchronous active high reset
module rx_mode_sequencer_properties
	import rx_seq_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_sequencer_disable,
	input wire logic i_low_index_correction_enable,
	input wire logic [7:0] i_low_index_offset,
	input wire logic i_pll_locked,
	input wire logic [7:0] i_adc_sample,
	input wire logic i_adc_valid,
	input wire logic i_demod_data,
	input wire logic i_bit_sync_bypass,
	input wire logic [2:0] o_state,
	input wire block_en_t o_block_en,
	input wire logic o_pll_lock,
	input wire logic o_timeout_irq,
	input wire logic o_correction_done,
	input wire logic [31:0] o_low_index_offset_hz,
	input wire logic o_temp_running_flag,
	input wire logic [7:0] o_temp_value,
	input wire logic o_serial_data
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);
	// --------------------------------
	// helper logic
	// --------------------------------
	// counts how long a measurement has been running
	logic [15:0] run_cnt_r;
	always_ff @(posedge i_clock) begin
		if (i_srst || !o_temp_running_flag)
			run_cnt_r <= 16'h0000;
		else
			run_cnt_r <= run_cnt_r + 16'h0001;
	end
	sequence s_rx_up;
		!i_sequencer_disable && $rose(o_block_en.rx_on);
	endsequence
	// --------------------------------
	// properties
	// --------------------------------
	a_reset_clears: assert property (disable iff (1'b0) i_srst |=> o_state == 3'h0 && !o_timeout_irq)
		else $error("outputs not cleared by reset");
	a_sleep_all_off: assert property ((o_state == 3'h0)[*3] |-> o_block_en == 4'h0)
		else $error("blocks powered in sleep");
	a_rx_after_synth: assert property (s_rx_up |-> $past(o_block_en.synth_on))
		else $error("receiver woke before synthesizer");
	a_lock_follows_pll: assert property ($rose(o_pll_lock) |-> $past(i_pll_locked))
		else $error("lock output rose without pll lock");
	a_offset_scale: assert property (i_low_index_correction_enable |=>
		o_low_index_offset_hz == 32'($past(i_low_index_offset)) * 32'h000001E8)
		else $error("low index offset not field times 488");
	a_temp_gated: assert property ($rose(o_temp_running_flag) |-> o_state inside {3'h1, 3'h2})
		else $error("measurement started outside standby or synth");
	a_temp_inverted: assert property (o_temp_running_flag && i_adc_valid |=>
		o_temp_value == ~$past(i_adc_sample))
		else $error("temperature value not inverted sample");
	a_temp_bounded: assert property (o_temp_running_flag |-> run_cnt_r < 16'h61A8)
		else $error("measurement ran past 100 us");
	a_timeout_pulse: assert property (o_timeout_irq |=> !o_timeout_irq)
		else $error("timeout longer than one cycle");
	a_corr_pulse: assert property ($rose(o_correction_done) |=> $fell(o_correction_done))
		else $error("correction done longer than one cycle");
	a_serial_gate: assert property (o_serial_data |-> $past(i_bit_sync_bypass && i_demod_data))
		else $error("serial data without bypass and data");
	a_wide_bw_corr: assert property (o_block_en.wide_bw == (o_state == 3'h4))
		else $error("wide bandwidth outside correction");
endmodule : rx_mode_sequencer_properties

// ==== bench/rx_mode_sequencer_test.sv ====
// self-checking bench for the receive mode sequencer
// assumes the front end model and port checker beside it
module rx_mode_sequencer_test
	import rx_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clock = 1'b0, i_srst = 1'b1, i_listen_enable = 1'b0, i_sequencer_disable = 1'b1;
	logic i_auto_correction_enable = 1'b0, i_correction_start = 1'b0, i_ook_mode = 1'b0;
	logic i_auto_correction_clear = 1'b0, i_low_index_correction_enable = 1'b0;
	logic i_freq_error_valid, i_carrier_freq_we = 1'b0, i_osc_ready, i_pll_locked, i_temp_start = 1'b0;
	logic i_adc_valid, i_signal_threshold_flag = 1'b0, i_demod_data = 1'b1, i_bit_sync_bypass = 1'b1;
	logic [2:0] i_mode = 3'h0, o_state;
	logic [7:0] i_low_index_offset = 8'h03, i_adc_sample, o_temp_value;
	logic [7:0] i_rx_start_timeout_field = 8'h00, i_threshold_timeout_field = 8'h00;
	logic [15:0] i_freq_error_value, o_freq_correction_value;
	logic [15:0] i_bit_period_cyc = 16'h0004, i_filter_rxbw_cyc = 16'h0008;
	logic [23:0] i_carrier_freq_wdata = 24'h123456, o_carrier_freq_regs;
	block_en_t o_block_en;
	logic o_pll_lock, o_receiver_ready_irq, o_timeout_irq, o_correction_done;
	logic o_temp_running_flag, o_serial_data;
	logic [31:0] o_low_index_offset_hz;
	int bad_count = 0, n_compared = 0, cyc = 0, n;
	rx_mode_sequencer dut (.*);
	rx_front_model fe (.i_clock(i_clock), .i_block_en(o_block_en),
		.i_temp_running_flag(o_temp_running_flag), .o_osc_ready(i_osc_ready),
		.o_pll_locked(i_pll_locked), .o_freq_error_value(i_freq_error_value),
		.o_freq_error_valid(i_freq_error_valid), .o_adc_sample(i_adc_sample),
		.o_adc_valid(i_adc_valid));
	always #2 i_clock = ~i_clock;
	// two rx entries of about 4200 to 4300 cycles each and one manual correction cut short after its done pulse fit well inside this
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			close_out();
		end
	end
	// --------------------------------
	// shared tasks
	// --------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic tick(input int k);
		repeat (k) @(negedge i_clock);
	endtask : tick
	task automatic wait_lvl(ref logic s, input logic v, output int k);
		k = 0;
		while (s !== v && k < 30000) begin
			@(negedge i_clock);
			k++;
		end
	endtask : wait_lvl
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_modes;
		for (int m = 0; m < 3; m++) begin
			i_mode = 3'(m);
			tick(8);
			chk("state", 32'(m), 32'(o_state));
			chk("synth rx", (m == 2) ? 32'h2 : 32'h0, {o_block_en.synth_on, o_block_en.rx_on});
			if (m < 2)
				chk("osc", 32'(m), 32'(o_block_en.osc_on));
		end
		i_listen_enable = 1'b1;
		tick(8);
		chk("listen state", 32'h7, 32'(o_state));
		i_listen_enable = 1'b0;
		$display("t_modes done");
	endtask : t_modes
	task automatic t_temp;
		i_mode = 3'h0;
		tick(8);
		i_temp_start = 1'b1;
		tick(1);
		i_temp_start = 1'b0;
		tick(5);
		chk("temp refused", 32'h0, 32'(o_temp_running_flag));
		i_mode = 3'h1;
		tick(30);
		i_temp_start = 1'b1;
		tick(1);
		i_temp_start = 1'b0;
		wait_lvl(o_temp_running_flag, 1'b1, n);
		chk("temp started", 32'h1, 32'(n <= 3));
		wait_lvl(o_temp_running_flag, 1'b0, n);
		chk("temp ended", 32'h1, 32'(n < 25000));
		chk("temp value", 32'hA5, 32'(o_temp_value));
		$display("t_temp done");
	endtask : t_temp
	task automatic t_wake;
		bit saw1 = 0, saw2 = 0;
		i_mode = 3'h0;
		i_sequencer_disable = 1'b0;
		i_carrier_freq_we = 1'b1;
		tick(1);
		i_carrier_freq_we = 1'b0;
		tick(8);
		i_auto_correction_enable = 1'b1;
		i_mode = 3'h4;
		n = 0;
		while (o_receiver_ready_irq !== 1'b1 && n < 9000) begin
			@(negedge i_clock);
			saw1 |= o_state === 3'h1;
			saw2 |= o_state === 3'h2;
			n++;
		end
		chk("via standby synth", 32'h3, {saw1, saw2});
		// settle 42, sample 16, relock 4166 cycles at least
		chk("startup length", 32'h1, 32'(n >= 4224 && n < 9000));
		chk("auto corrected", 32'h123466, 32'(o_carrier_freq_regs));
		$display("t_wake done");
	endtask : t_wake
	task automatic t_manual;
		i_auto_correction_enable = 1'b0;
		i_correction_start = 1'b1;
		tick(1);
		i_correction_start = 1'b0;
		wait_lvl(o_correction_done, 1'b1, n);
		tick(2);
		chk("manual corrected", 32'h123476, 32'(o_carrier_freq_regs));
		chk("amount", 32'hFFF0, 32'(o_freq_correction_value));
		i_low_index_correction_enable = 1'b1;
		tick(3);
		chk("offset hz", 32'h5B8, o_low_index_offset_hz);
		i_low_index_correction_enable = 1'b0;
		$display("t_manual done");
	endtask : t_manual
	task automatic t_timeout;
		i_auto_correction_enable = 1'b1;
		i_auto_correction_clear = 1'b1;
		i_rx_start_timeout_field = 8'h02;
		// hop through synth then back to rx
		i_mode = 3'h2;
		tick(10);
		i_mode = 3'h4;
		// timeout counts from rx entry, long before ready
		wait_lvl(o_timeout_irq, 1'b1, n);
		chk("rx start timeout", 32'h1, 32'(n >= 58 && n <= 66));
		wait_lvl(o_receiver_ready_irq, 1'b1, n);
		chk("cleared then corrected", 32'h123466, 32'(o_carrier_freq_regs));
		chk("serial data", 32'h1, 32'(o_serial_data));
		i_threshold_timeout_field = 8'h03;
		i_signal_threshold_flag = 1'b1;
		wait_lvl(o_timeout_irq, 1'b1, n);
		chk("threshold timeout", 32'h1, 32'(n >= 92 && n <= 99));
		i_demod_data = 1'b0;
		tick(3);
		chk("serial low", 32'h0, 32'(o_serial_data));
		$display("t_timeout done");
	endtask : t_timeout
	initial begin
		tick(2);
		i_srst = 1'b0;
		t_modes();
		t_temp();
		t_wake();
		t_manual();
		t_timeout();
		close_out();
	end
endmodule : rx_mode_sequencer_test
bind rx_mode_sequencer rx_mode_sequencer_properties u_props (.*);

// ==== common/rx_seq_defs.svh ====
// timing counts and encodings for the receive mode sequencer
// assumes a 250 MHz core clock and a bit period given in clock cycles
`ifndef RX_SEQ_DEFS_SVH
`define RX_SEQ_DEFS_SVH
`define CLK_PERIOD_PS 4000
`define TEMP_MEAS_US 100
`define TEMP_MEAS_CYC ((`TEMP_MEAS_US * 1000000) / `CLK_PERIOD_PS)
`define PLL_BW_KHZ 300
// kept inside 32 bits: 5 / 300 kHz in 4 ns cycles
`define PLL_RELOCK_CYC ((5 * 1000000) / (`PLL_BW_KHZ * (`CLK_PERIOD_PS / 1000)))
`define CORR_SAMPLE_BITS 4
`define TIMEOUT_BITS_PER_LSB 8
`define LOW_INDEX_STEP_HZ 488
`define CF_FSK_NUM 21
`define CF_OOK_NUM 34
`define MODE_SLEEP 3'h0
`define MODE_STANDBY 3'h1
`define MODE_SYNTH 3'h2
`define MODE_RX 3'h4
`define FREQ_RST 24'h000000
`define TEMP_RST 8'h00
`endif

// ==== common/rx_seq_pkg.sv ====
// types for the receive mode sequencer
// assumes rx_seq_defs.svh is on the include path
package rx_seq_pkg;
	typedef enum logic [2:0] {
		ST_SLEEP = 3'b000,
		ST_STANDBY = 3'b001,
		ST_SYNTH = 3'b010,
		ST_RX_SETTLE = 3'b011,
		ST_RX_CORR = 3'b100,
		ST_RX_RELOCK = 3'b101,
		ST_RX = 3'b110,
		ST_LISTEN = 3'b111
	} seq_state_t;
	typedef struct packed {
		logic osc_on;
		logic synth_on;
		logic rx_on;
		logic wide_bw;
	} block_en_t;
endpackage : rx_seq_pkg

// ==== hdl/rx_mode_sequencer.sv ====
// receiver operating mode controller: sequencer, correction, temperature, timeouts
// assumes configuration bits arrive as synchronous levels and analog events as pulses
`include "rx_seq_defs.svh"

// Function
// R1 - finished correction is subtracted from the carrier frequency register
// R2 - auto correction enabled launches a correction on every receiver enable; with i_sequencer_disable set the code stays in ST_RX_SETTLE and launches none
// R3 - with auto off, a start pulse runs one correction
// R4 - auto clear discards old correction, else evaluate from corrected frequency
// R5 - correction phase uses the wide correction bandwidth setting
// R6 - low index offset equals offset field times 488 Hz
// R7 - low index mode corrects by error plus offset
// R8 - temperature trigger accepted only in standby or synth; uses receiver converter
// R9 - temperature result falls one lsb per degree rise
// R10 - temperature running flag clears within 100 us of start
// R11 - timeout after rx start field times 8 bits without threshold flag
// R12 - timeout after threshold field times 8 bits after threshold flag
// R13 - mode codes 000 sleep, 001 standby, 010 synth
// R14 - mode 100 receive; listen bit overrides the mode field
// R15 - sequencer wakes blocks in order; disable bit enters mode directly; code orders wakeup only toward receive
// R16 - sleep to receive goes standby, synth, then receive after pll lock
// R17 - pll lock output high when synthesizer reaches lock
// R18 - startup allows 4 bit correction sample then 5/300 kHz relock
// R19 - filter settling is 21 or 34 over four times receive bandwidth
// R20 - without bit sync, data valid right after receiver ready
// R21 - transmitter sends 12 preamble bits after receiver ready
// R22 - controller hops by writing frequency, synth mode, then receive
module rx_mode_sequencer
	import rx_seq_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic [2:0] i_mode,
	input wire logic i_listen_enable,
	input wire logic i_sequencer_disable,
	input wire logic i_auto_correction_enable,
	input wire logic i_correction_start,
	input wire logic i_auto_correction_clear,
	input wire logic i_low_index_correction_enable,
	input wire logic [7:0] i_low_index_offset,
	input wire logic [15:0] i_freq_error_value,
	input wire logic i_freq_error_valid,
	input wire logic [23:0] i_carrier_freq_wdata,
	input wire logic i_carrier_freq_we,
	input wire logic i_osc_ready,
	input wire logic i_pll_locked,
	input wire logic i_ook_mode,
	input wire logic [15:0] i_bit_period_cyc,
	input wire logic [15:0] i_filter_rxbw_cyc,
	input wire logic i_temp_start,
	input wire logic [7:0] i_adc_sample,
	input wire logic i_adc_valid,
	input wire logic [7:0] i_rx_start_timeout_field,
	input wire logic [7:0] i_threshold_timeout_field,
	input wire logic i_signal_threshold_flag,
	input wire logic i_demod_data,
	input wire logic i_bit_sync_bypass,
	output logic [2:0] o_state,
	output block_en_t o_block_en,
	output logic o_pll_lock,
	output logic o_receiver_ready_irq,
	output logic o_timeout_irq,
	output logic o_correction_done,
	output logic [23:0] o_carrier_freq_regs,
	output logic [15:0] o_freq_correction_value,
	output logic [31:0] o_low_index_offset_hz,
	output logic o_temp_running_flag,
	output logic [7:0] o_temp_value,
	output logic o_serial_data
);

	// ----------------------------------------
	// target decode
	// ----------------------------------------
	seq_state_t state_r, state_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic corr_pend_r;
	logic [15:0] corr_acc_r;
	logic temp_busy_r;
	logic [15:0] temp_cnt_r;
	logic to_thr_r;
	logic [31:0] to_cnt_r;

	function automatic seq_state_t mode_to_state(input logic lsn, input logic [2:0] m);
		seq_state_t s;
		s = ST_SLEEP;
		// R14 listen override
		if (lsn) s = ST_LISTEN;
		else if (m == `MODE_STANDBY) s = ST_STANDBY;
		else if (m == `MODE_SYNTH) s = ST_SYNTH;
		else if (m == `MODE_RX) s = ST_RX_SETTLE;
		return s;
	endfunction : mode_to_state

	// R13 mode code decode
	wire seq_state_t target = mode_to_state(i_listen_enable, i_mode);
	wire logic want_rx = (target == ST_RX_SETTLE);
	wire logic in_rx = (state_r == ST_RX_SETTLE) || (state_r == ST_RX_CORR)
		|| (state_r == ST_RX_RELOCK) || (state_r == ST_RX);
	wire logic [15:0] cf_num = i_ook_mode ? 16'(`CF_OOK_NUM) : 16'(`CF_FSK_NUM);
	// R19 filter settle count
	wire logic [31:0] settle_cyc = 32'(cf_num) * 32'(i_filter_rxbw_cyc) / 32'h4;
	// R18 correction sample
	wire logic [31:0] sample_cyc = 32'(`CORR_SAMPLE_BITS) * 32'(i_bit_period_cyc);
	// R2 auto launch / R3 manual start
	wire logic corr_req = i_auto_correction_enable | corr_pend_r;
	// R7 error plus offset in low index mode
	wire logic [15:0] corr_amt = i_low_index_correction_enable ?
		(i_freq_error_value + 16'(i_low_index_offset)) : i_freq_error_value;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r + 32'h1;
		// R15 direct entry when sequencer disabled
		if (i_sequencer_disable) begin
			if (!(want_rx && in_rx) && state_r != target) begin
				state_nxt = target;
				cnt_nxt = 32'h0;
			end
		end else if (!want_rx && state_r != target) begin
			state_nxt = target;
			cnt_nxt = 32'h0;
		end else if (want_rx) begin
			unique case (state_r)
				// R16 sleep passes through standby and synth
				ST_SLEEP, ST_LISTEN: begin
					state_nxt = ST_STANDBY;
					cnt_nxt = 32'h0;
				end
				ST_STANDBY: if (i_osc_ready) begin
					state_nxt = ST_SYNTH;
					cnt_nxt = 32'h0;
				end
				// R16 wait for pll lock
				ST_SYNTH: if (i_pll_locked) begin
					state_nxt = ST_RX_SETTLE;
					cnt_nxt = 32'h0;
				end
				ST_RX_SETTLE: if (cnt_r >= settle_cyc) begin
					state_nxt = corr_req ? ST_RX_CORR : ST_RX;
					cnt_nxt = 32'h0;
				end
				ST_RX_CORR: if (cnt_r >= sample_cyc && i_freq_error_valid) begin
					state_nxt = ST_RX_RELOCK;
					cnt_nxt = 32'h0;
				end
				// R18 pll relock after correction
				ST_RX_RELOCK: if (cnt_r >= 32'(`PLL_RELOCK_CYC)) begin
					state_nxt = ST_RX;
					cnt_nxt = 32'h0;
				end
				ST_RX: begin
					if (i_correction_start && !i_auto_correction_enable) begin
						state_nxt = ST_RX_CORR;
						cnt_nxt = 32'h0;
					end
				end
			endcase
		end
	end

	wire logic rx_enter = want_rx && !in_rx && (state_nxt == ST_RX_SETTLE);
	wire logic corr_fin = (state_r == ST_RX_CORR) && (state_nxt == ST_RX_RELOCK);
	// R8 temperature only in standby or synth
	wire logic temp_ok = (state_r == ST_STANDBY) || (state_r == ST_SYNTH);
	wire logic [31:0] to_limit = to_thr_r ?
		32'(i_threshold_timeout_field) * 32'(`TIMEOUT_BITS_PER_LSB) * 32'(i_bit_period_cyc) :
		32'(i_rx_start_timeout_field) * 32'(`TIMEOUT_BITS_PER_LSB) * 32'(i_bit_period_cyc);
	wire logic to_field_on = to_thr_r ? (i_threshold_timeout_field != 8'h00)
		: (i_rx_start_timeout_field != 8'h00);

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			state_r <= ST_SLEEP;
			cnt_r <= 32'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// ----------------------------------------
	// frequency correction
	// ----------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			corr_pend_r <= 1'b0;
			corr_acc_r <= 16'h0000;
			o_carrier_freq_regs <= `FREQ_RST;
			o_freq_correction_value <= 16'h0000;
			o_correction_done <= 1'b0;
		end else begin
			o_correction_done <= corr_fin;
			// R3 manual start held until a correction runs
			if (i_correction_start && !i_auto_correction_enable)
				corr_pend_r <= 1'b1;
			else if (corr_fin)
				corr_pend_r <= 1'b0;
			if (i_carrier_freq_we) begin
				o_carrier_freq_regs <= i_carrier_freq_wdata;
				corr_acc_r <= 16'h0000;
			end else if (rx_enter && i_auto_correction_enable && i_auto_correction_clear) begin
				// R4 discard previous correction
				o_carrier_freq_regs <= o_carrier_freq_regs + 24'(signed'(corr_acc_r));
				corr_acc_r <= 16'h0000;
			end else if (corr_fin) begin
				// R1 subtract correction from carrier
				o_carrier_freq_regs <= o_carrier_freq_regs - 24'(signed'(corr_amt));
				corr_acc_r <= corr_acc_r + corr_amt;
				o_freq_correction_value <= corr_amt;
			end
		end
	end

	// ----------------------------------------
	// temperature and timeout
	// ----------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			temp_busy_r <= 1'b0;
			temp_cnt_r <= 16'h0000;
			o_temp_running_flag <= 1'b0;
			o_temp_value <= `TEMP_RST;
			to_thr_r <= 1'b0;
			to_cnt_r <= 32'h0;
			o_timeout_irq <= 1'b0;
		end else begin
			if (i_temp_start && temp_ok && !temp_busy_r) begin
				temp_busy_r <= 1'b1;
				temp_cnt_r <= 16'h0000;
			end else if (temp_busy_r) begin
				temp_cnt_r <= temp_cnt_r + 16'h0001;
				// R10 forced end bounds the measurement
				if (i_adc_valid || temp_cnt_r >= 16'(`TEMP_MEAS_CYC - 2)) begin
					temp_busy_r <= 1'b0;
				end
				// R9 inverted slope result
				if (i_adc_valid)
					o_temp_value <= ~i_adc_sample;
			end
			o_temp_running_flag <= temp_busy_r;
			o_timeout_irq <= 1'b0;
			if (!in_rx) begin
				to_thr_r <= 1'b0;
				to_cnt_r <= 32'h0;
			end else if (i_signal_threshold_flag && !to_thr_r) begin
				to_thr_r <= 1'b1;
				to_cnt_r <= 32'h0;
			end else begin
				to_cnt_r <= to_cnt_r + 32'h1;
				// R11 rx start timeout / R12 threshold timeout
				if (to_field_on && to_cnt_r + 32'h1 == to_limit)
					o_timeout_irq <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_state <= 3'h0;
			o_block_en <= '0;
			o_pll_lock <= 1'b0;
			o_receiver_ready_irq <= 1'b0;
			o_serial_data <= 1'b0;
			o_low_index_offset_hz <= 32'h0;
		end else begin
			o_state <= state_r;
			o_block_en.osc_on <= (state_r != ST_SLEEP);
			o_block_en.synth_on <= (state_r != ST_SLEEP) && (state_r != ST_STANDBY);
			// R8 converter borrowed while measuring
			o_block_en.rx_on <= in_rx || temp_busy_r;
			// R5 wide bandwidth during correction
			o_block_en.wide_bw <= (state_r == ST_RX_CORR);
			// R17 lock indication
			o_pll_lock <= i_pll_locked && o_block_en.synth_on;
			// R21 ready marks where the preamble count begins
			o_receiver_ready_irq <= (state_r == ST_RX);
			// R20 bypassed data follows ready directly
			o_serial_data <= (state_r == ST_RX) && i_bit_sync_bypass && i_demod_data;
			// R6 offset in hertz
			o_low_index_offset_hz <= i_low_index_correction_enable ?
				32'(i_low_index_offset) * 32'(`LOW_INDEX_STEP_HZ) : 32'h0;
		end
	end
endmodule : rx_mode_sequencer
